// ### rtl/rxs_status_bank.sv
// rxs_status_bank: paged status registers of four receive ports.
// assumes: reg_rd_in pulses once per completed read, reg_wr_in once per write;
// receiver event inputs are one-cycle pulses on core_clk_in, levels are steady.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// RULE_01 - lock-change bit 4 sets on any lock change, clears when status one is read
// RULE_02 - enhanced reporting off: bit 3 latches control sequence fault, read clears
// RULE_03 - enhanced reporting on: bit 3 summarises faults, clears on detail read
// RULE_04 - parity bit 2 high while parity count exceeds threshold; clears with counters
// RULE_05 - bit 1 shows live pass indication of the receive input
// RULE_06 - bit 0 shows live receiver lock, reset value zero
// RULE_07 - status two bit 7 latches unsteady line width, read clears
// RULE_08 - status two bit 6 latches line width change, read clears
// RULE_09 - bit 5 latches encoding fault, only when link fault counting above one
// RULE_10 - bit 4 latches packet buffer overflow, read clears
// RULE_11 - bit 3 shows live receive error summary, read-only
// RULE_12 - bit 1 high while link clock missing; bit 2 shows frequency settled
// RULE_13 - bit 0 latches line count change, read clears
// RULE_14 - frequency read as integer MHz byte and 1/256 MHz fraction byte
// RULE_15 - alarm register loads from forward channel; software writes ignored
// RULE_16 - alarm bits: csi 5, backchannel 4, link 3, temp 2, volt1 1, volt0 0
// RULE_17 - page select chooses which port's registers a read returns
// RULE_18 - reading parity low byte clears both parity count bytes
// RULE_19 - a set arriving with its clearing read wins
// RULE_20 - read clears act only on the selected port, once per read
module rxs_status_bank import rxs_pkg::*; (
  input  wire logic                                     core_clk_in,                   // core clock
  input  wire logic                                     rst_n_in,                      // async reset, low
  input  wire logic [7:0]                               reg_addr_in,                   // register offset
  input  wire logic                                     reg_wr_in,                     // write strobe
  input  wire logic                                     reg_rd_in,                     // read strobe
  input  wire logic [7:0]                               reg_wdata_in,                  // write data
  output logic      [7:0]                               reg_rdata_out,                 // read data
  input  wire logic [RXS_NPORT-1:0]                     rx_locked_in,                  // lock level
  input  wire logic [RXS_NPORT-1:0]                     rx_pass_in,                    // pass level
  input  wire logic [RXS_NPORT-1:0]                     parity_err_in,                 // parity error pulse
  input  wire logic [RXS_NPORT-1:0]                     ctrl_chan_sequence_fault_in,   // sequence fault pulse
  input  wire logic [RXS_NPORT-1:0][RXS_DETAIL_W-1:0]   ctrl_chan_fault_detail_in,     // fault kind pulses
  input  wire logic [RXS_NPORT-1:0]                     line_width_unsteady_in,        // unsteady pulse
  input  wire logic [RXS_NPORT-1:0]                     line_width_changed_in,         // width change pulse
  input  wire logic [RXS_NPORT-1:0]                     link_encoding_fault_in,        // encoding pulse
  input  wire logic [RXS_NPORT-1:0]                     buffer_overflow_in,            // overflow pulse
  input  wire logic [RXS_NPORT-1:0]                     line_total_changed_in,         // count change pulse
  input  wire logic [RXS_NPORT-1:0]                     csi_receive_error_in,          // csi error level
  input  wire logic [RXS_NPORT-1:0]                     freq_measure_settled_in,       // settled level
  input  wire logic [RXS_NPORT-1:0]                     link_clock_missing_in,         // no clock level
  input  wire logic [RXS_NPORT-1:0][7:0]                freq_integer_mhz_in,           // MHz part
  input  wire logic [RXS_NPORT-1:0][7:0]                freq_fraction_in,              // 1/256 MHz part
  input  wire logic [RXS_NPORT-1:0]                     remote_alarm_valid_in,         // alarm load pulse
  input  wire logic [RXS_NPORT-1:0][RXS_ALARM_W-1:0]    remote_alarm_in,               // alarm flags
  output logic                                          enhanced_ctrl_fault_enable_out // selected port mode
);

  // ************************************************************
  // page select and access decode
  // ************************************************************
  logic [RXS_SEL_W-1:0] rx_page_select_q;
  logic [RXS_NPORT-1:0] wr_port_en_q;
  logic                 rd_sts1;
  logic                 rd_sts2;
  logic                 rd_parl;
  logic                 rd_cdet;
  logic                 wr_page;

  assign wr_page = reg_wr_in && (reg_addr_in == RXS_ADR_PAGE);
  assign rd_sts1 = reg_rd_in && (reg_addr_in == RXS_ADR_STS1);
  assign rd_sts2 = reg_rd_in && (reg_addr_in == RXS_ADR_STS2);
  assign rd_parl = reg_rd_in && (reg_addr_in == RXS_ADR_PARL);
  assign rd_cdet = reg_rd_in && (reg_addr_in == RXS_ADR_CDET);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_page_select_q <= RXS_PAGE_RST[RXS_PG_RD_LSB +: RXS_SEL_W];
      wr_port_en_q     <= RXS_PAGE_RST[RXS_NPORT-1:0];
    end else if (wr_page) begin
      rx_page_select_q <= reg_wdata_in[RXS_PG_RD_LSB +: RXS_SEL_W]; // [RULE_17]
      wr_port_en_q     <= reg_wdata_in[RXS_NPORT-1:0];
    end
  end

  // ************************************************************
  // per-port registers and flag keepers
  // ************************************************************
  logic [RXS_NPORT-1:0][7:0]              sts1_v;
  logic [RXS_NPORT-1:0][7:0]              sts2_v;
  logic [RXS_NPORT-1:0][7:0]              cctl_q;
  logic [RXS_NPORT-1:0][7:0]              lnkc_q;
  logic [RXS_NPORT-1:0][RXS_PAR_W-1:0]    thr_q;
  logic [RXS_NPORT-1:0][RXS_PAR_W-1:0]    par_cnt_v;
  logic [RXS_NPORT-1:0][RXS_DETAIL_W-1:0] detail_v;
  logic [RXS_NPORT-1:0][RXS_ALARM_W-1:0]  alarm_q;

  for (genvar p = 0; p < RXS_NPORT; p++) begin : g_port
    rxs_flag_if fif ();
    logic sel_here;
    logic wr_here;
    logic enc_gate;
    logic cc_bit;

    assign sel_here = (rx_page_select_q == RXS_SEL_W'(p));
    assign wr_here  = reg_wr_in && wr_port_en_q[p];

    // writes reach every port whose write enable is set
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        cctl_q[p] <= RXS_CCTL_RST;
        lnkc_q[p] <= RXS_LNKC_RST;
        thr_q[p]  <= RXS_PAR_THR_RST;
      end else if (wr_here) begin
        if (reg_addr_in == RXS_ADR_CCTL) cctl_q[p] <= reg_wdata_in;
        if (reg_addr_in == RXS_ADR_LNKC) lnkc_q[p] <= reg_wdata_in;
        if (reg_addr_in == RXS_ADR_THRH) thr_q[p][RXS_PAR_W-1:8] <= reg_wdata_in;
        if (reg_addr_in == RXS_ADR_THRL) thr_q[p][7:0] <= reg_wdata_in;
      end
    end

    // alarm byte has no write path at all
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) alarm_q[p] <= '0;
      else if (remote_alarm_valid_in[p]) alarm_q[p] <= remote_alarm_in[p]; // [RULE_15] [RULE_16]
    end

    // below threshold two the lock loss hides the fault, so it is not latched
    assign enc_gate = lnkc_q[p][RXS_LNKC_EN] &&
                      (lnkc_q[p][RXS_LNK_THR_W-1:0] > RXS_LNK_THR_MIN); // [RULE_09]

    assign fif.ev_lock    = rx_locked_in[p];
    assign fif.ev_seq     = ctrl_chan_sequence_fault_in[p];
    assign fif.ev_par     = parity_err_in[p];
    assign fif.ev_detail  = ctrl_chan_fault_detail_in[p];
    assign fif.enh        = cctl_q[p][RXS_CCTL_ENH];
    assign fif.par_thresh = thr_q[p];

    always_comb begin
      fif.ev_stk               = '0;
      fif.ev_stk[RXS_STK_OVF]  = buffer_overflow_in[p];
      fif.ev_stk[RXS_STK_ENC]  = link_encoding_fault_in[p] && enc_gate; // [RULE_09]
      fif.ev_stk[RXS_STK_WCHG] = line_width_changed_in[p];
      fif.ev_stk[RXS_STK_UNST] = line_width_unsteady_in[p];
      fif.ev_stk[RXS_STK_W-1]  = line_total_changed_in[p];
    end

    // clears only for the page being read
    assign fif.clr_sts1   = rd_sts1 && sel_here; // [RULE_20]
    assign fif.clr_sts2   = rd_sts2 && sel_here; // [RULE_20]
    assign fif.clr_detail = rd_cdet && sel_here; // [RULE_20] [RULE_03]
    assign fif.clr_parity = rd_parl && sel_here; // [RULE_18] [RULE_20]

    rxs_port_flags u_flags (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .fif         (fif.flags)
    );

    assign cc_bit = fif.enh ? (|fif.detail) : fif.seq_flag; // [RULE_02] [RULE_03]

    always_comb begin
      sts1_v[p]                                   = '0;
      sts1_v[p][RXS_S1_LOCK]                      = rx_locked_in[p];  // [RULE_06]
      sts1_v[p][RXS_S1_PASS]                      = rx_pass_in[p];    // [RULE_05]
      sts1_v[p][RXS_S1_PAR]                       = fif.par_flag;     // [RULE_04]
      sts1_v[p][RXS_S1_CC]                        = cc_bit;
      sts1_v[p][RXS_S1_LCHG]                      = fif.lock_chg;     // [RULE_01]
      sts1_v[p][RXS_S1_NUM_LSB +: RXS_SEL_W]      = rx_page_select_q; // [RULE_17]
    end

    always_comb begin
      sts2_v[p]                                   = '0;
      sts2_v[p][RXS_S2_TCHG]                      = fif.stk[RXS_STK_W-1];       // [RULE_13]
      sts2_v[p][RXS_S2_NOCLK]                     = link_clock_missing_in[p];   // [RULE_12]
      sts2_v[p][RXS_S2_SETTLE]                    = freq_measure_settled_in[p]; // [RULE_12]
      sts2_v[p][RXS_S2_CSI]                       = csi_receive_error_in[p];    // [RULE_11]
      sts2_v[p][RXS_S2_STK_LSB +: RXS_STK_W-1]    = fif.stk[RXS_STK_W-2:0];     // [RULE_07] [RULE_08] [RULE_10]
    end

    assign par_cnt_v[p] = fif.par_cnt;
    assign detail_v[p]  = fif.detail;
  end

  assign enhanced_ctrl_fault_enable_out = cctl_q[rx_page_select_q][RXS_CCTL_ENH];

  // ************************************************************
  // read data
  // ************************************************************
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  always_comb begin
    rdata_d = '0;
    unique case (reg_addr_in)
      RXS_ADR_PAGE: begin
        rdata_d[RXS_PG_PHY_LSB +: RXS_SEL_W] = RXS_PHYS_PORT_LOCAL;
        rdata_d[RXS_PG_RD_LSB +: RXS_SEL_W]  = rx_page_select_q;
        rdata_d[RXS_NPORT-1:0]               = wr_port_en_q;
      end
      RXS_ADR_STS1: rdata_d = sts1_v[rx_page_select_q];                           // [RULE_17]
      RXS_ADR_STS2: rdata_d = sts2_v[rx_page_select_q];
      RXS_ADR_FRQI: rdata_d = freq_integer_mhz_in[rx_page_select_q];              // [RULE_14]
      RXS_ADR_FRQF: rdata_d = freq_fraction_in[rx_page_select_q];                 // [RULE_14]
      RXS_ADR_ALRM: rdata_d[RXS_ALARM_W-1:0] = alarm_q[rx_page_select_q];         // [RULE_16]
      RXS_ADR_PARH: rdata_d = par_cnt_v[rx_page_select_q][RXS_PAR_W-1:8];
      RXS_ADR_PARL: rdata_d = par_cnt_v[rx_page_select_q][7:0];
      RXS_ADR_CCTL: rdata_d = cctl_q[rx_page_select_q];
      RXS_ADR_CDET: rdata_d = detail_v[rx_page_select_q];
      RXS_ADR_THRH: rdata_d = thr_q[rx_page_select_q][RXS_PAR_W-1:8];
      RXS_ADR_THRL: rdata_d = thr_q[rx_page_select_q][7:0];
      RXS_ADR_LNKC: rdata_d = lnkc_q[rx_page_select_q];
      default:      rdata_d = '0;
    endcase
  end

  // captured on the same edge that applies the read clear, so software sees the pre-clear value
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) rdata_q <= '0;
    else if (reg_rd_in) rdata_q <= rdata_d;
  end
  assign reg_rdata_out = rdata_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_lock_live_read: assert property (rd_sts1 |=>
    reg_rdata_out[RXS_S1_LOCK] == $past(rx_locked_in[rx_page_select_q])) // [RULE_06]
    else $error("status one lock bit wrong");
  a_page_number: assert property (rd_sts1 |=>
    reg_rdata_out[RXS_S1_NUM_LSB +: RXS_SEL_W] == $past(rx_page_select_q)) // [RULE_17]
    else $error("status one port number wrong");
  a_pass_live_read: assert property (rd_sts1 |=>
    reg_rdata_out[RXS_S1_PASS] == $past(rx_pass_in[rx_page_select_q])) // [RULE_05]
    else $error("status one pass bit wrong");
  a_other_port_kept: assert property (rd_sts2 && rx_page_select_q != 2'h0 &&
    g_port[0].fif.stk[RXS_STK_OVF] |=> g_port[0].fif.stk[RXS_STK_OVF]) // [RULE_20]
    else $error("read cleared an unselected port");
  a_sts2_clear: assert property (rd_sts2 && rx_page_select_q == 2'h0 && !buffer_overflow_in[0] ##1
    !buffer_overflow_in[0] |-> !g_port[0].fif.stk[RXS_STK_OVF]) // [RULE_10]
    else $error("overflow flag survived its read");
  a_enc_masked: assert property (!g_port[0].enc_gate && !g_port[0].fif.stk[RXS_STK_ENC] |=>
    !g_port[0].fif.stk[RXS_STK_ENC]) // [RULE_09]
    else $error("encoding fault latched while counting disabled");
  a_alarm_load: assert property (remote_alarm_valid_in[1] |=> alarm_q[1] == $past(remote_alarm_in[1])) // [RULE_15]
    else $error("alarm byte not loaded");
  a_alarm_no_write: assert property (!remote_alarm_valid_in[1] |=> $stable(alarm_q[1])) // [RULE_15]
    else $error("alarm byte changed without a load");
  a_par_flag_read: assert property (rd_sts1 && rx_page_select_q == 2'h0 |=>
    reg_rdata_out[RXS_S1_PAR] == ($past(par_cnt_v[0]) > $past(thr_q[0]))) // [RULE_04]
    else $error("parity flag disagrees with count");

  a_csi_live_read: assert property (rd_sts2 |=>
    reg_rdata_out[RXS_S2_CSI] == $past(csi_receive_error_in[rx_page_select_q])) // [RULE_11]
    else $error("status two csi bit wrong");
  a_noclk_live_read: assert property (rd_sts2 |=>
    reg_rdata_out[RXS_S2_NOCLK] == $past(link_clock_missing_in[rx_page_select_q])) // [RULE_12]
    else $error("status two clock missing bit wrong");
  a_settle_live_read: assert property (rd_sts2 |=>
    reg_rdata_out[RXS_S2_SETTLE] == $past(freq_measure_settled_in[rx_page_select_q])) // [RULE_12]
    else $error("status two settled bit wrong");
  a_freq_int_read: assert property (reg_rd_in && reg_addr_in == RXS_ADR_FRQI |=>
    reg_rdata_out == $past(freq_integer_mhz_in[rx_page_select_q])) // [RULE_14]
    else $error("frequency integer byte wrong");
  a_freq_frac_read: assert property (reg_rd_in && reg_addr_in == RXS_ADR_FRQF |=>
    reg_rdata_out == $past(freq_fraction_in[rx_page_select_q])) // [RULE_14]
    else $error("frequency fraction byte wrong");
  a_alarm_read: assert property (reg_rd_in && reg_addr_in == RXS_ADR_ALRM |=>
    reg_rdata_out[RXS_ALARM_W-1:0] == $past(alarm_q[rx_page_select_q]) &&
    reg_rdata_out[7:RXS_ALARM_W] == '0) // [RULE_16]
    else $error("alarm byte read wrong");
  a_tchg_clear: assert property (rd_sts2 && rx_page_select_q == 2'h0 && !line_total_changed_in[0] |=>
    !g_port[0].fif.stk[RXS_STK_W-1]) // [RULE_13]
    else $error("line count flag survived its read");
  a_lock_chg_clear: assert property (rd_sts1 && rx_page_select_q == 2'h0 &&
    rx_locked_in[0] == g_port[0].u_flags.lock_prev_q |=> !g_port[0].fif.lock_chg) // [RULE_01]
    else $error("lock change flag survived its read");
  a_seq_read_clear: assert property (rd_sts1 && rx_page_select_q == 2'h0 && !cctl_q[0][RXS_CCTL_ENH] &&
    !ctrl_chan_sequence_fault_in[0] |=> !g_port[0].fif.seq_flag) // [RULE_02]
    else $error("sequence flag survived its read");
  a_cc_summary: assert property (rd_sts1 && enhanced_ctrl_fault_enable_out |=>
    reg_rdata_out[RXS_S1_CC] == $past(|detail_v[rx_page_select_q])) // [RULE_03]
    else $error("summary bit disagrees with detail");
  a_wr_gated_port: assert property (reg_wr_in && reg_addr_in == RXS_ADR_CCTL && !wr_port_en_q[0] |=>
    $stable(cctl_q[0])) // [RULE_17]
    else $error("write reached a disabled port");

  c_lock_change_read: cover property (g_port[0].fif.lock_chg && rd_sts1 && rx_page_select_q == 2'h0);
  c_alarm_loaded:     cover property (remote_alarm_valid_in[1] ##[1:20] reg_rd_in && reg_addr_in == RXS_ADR_ALRM);
  c_set_and_clear:    cover property (rd_sts2 && line_width_changed_in[rx_page_select_q]);
  c_enhanced_mode:    cover property (enhanced_ctrl_fault_enable_out && rd_cdet);
  c_parity_over:      cover property (g_port[2].fif.par_flag ##[1:20] rd_parl);
endmodule
`default_nettype wire

// ### rtl/rxs_pkg.sv
// rxs_pkg: constants of the per-port receive status register group.
// assumes: byte-wide register port fed by the local serial control slave.
package rxs_pkg;

  // ************************************************************
  // structure
  // ************************************************************
  localparam int RXS_NPORT     = 4;
  localparam int RXS_SEL_W     = 2;
  localparam int RXS_PAR_W     = 16;
  localparam int RXS_ALARM_W   = 6;
  localparam int RXS_DETAIL_W  = 8;
  localparam int RXS_LNK_THR_W = 3;
  localparam int RXS_STK_W     = 5;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] RXS_ADR_PAGE = 8'h4C;
  localparam logic [7:0] RXS_ADR_STS1 = 8'h4D;
  localparam logic [7:0] RXS_ADR_STS2 = 8'h4E;
  localparam logic [7:0] RXS_ADR_FRQI = 8'h4F;
  localparam logic [7:0] RXS_ADR_FRQF = 8'h50;
  localparam logic [7:0] RXS_ADR_ALRM = 8'h51;
  localparam logic [7:0] RXS_ADR_PARH = 8'h55;
  localparam logic [7:0] RXS_ADR_PARL = 8'h56;
  localparam logic [7:0] RXS_ADR_CCTL = 8'h5A;
  localparam logic [7:0] RXS_ADR_CDET = 8'h5B;
  localparam logic [7:0] RXS_ADR_THRH = 8'h5C;
  localparam logic [7:0] RXS_ADR_THRL = 8'h5D;
  localparam logic [7:0] RXS_ADR_LNKC = 8'h5E;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int RXS_PG_RD_LSB  = 4;
  localparam int RXS_PG_PHY_LSB = 6;
  localparam int RXS_S1_LOCK    = 0;
  localparam int RXS_S1_PASS    = 1;
  localparam int RXS_S1_PAR     = 2;
  localparam int RXS_S1_CC      = 3;
  localparam int RXS_S1_LCHG    = 4;
  localparam int RXS_S1_NUM_LSB = 6;
  localparam int RXS_S2_TCHG    = 0;
  localparam int RXS_S2_NOCLK   = 1;
  localparam int RXS_S2_SETTLE  = 2;
  localparam int RXS_S2_CSI     = 3;
  localparam int RXS_S2_STK_LSB = 4;
  localparam int RXS_STK_OVF    = 0;
  localparam int RXS_STK_ENC    = 1;
  localparam int RXS_STK_WCHG   = 2;
  localparam int RXS_STK_UNST   = 3;
  localparam int RXS_CCTL_ENH   = 0;
  localparam int RXS_LNKC_EN    = 3;

  // ************************************************************
  // reset values and fixed constants
  // ************************************************************
  localparam logic [5:0]                 RXS_PAGE_RST       = 6'h00;
  localparam logic [1:0]                 RXS_PHYS_PORT_LOCAL = 2'h0;
  localparam logic [7:0]                 RXS_CCTL_RST       = 8'h00;
  localparam logic [7:0]                 RXS_LNKC_RST       = 8'h00;
  localparam logic [RXS_PAR_W-1:0]       RXS_PAR_THR_RST    = 16'h0000;
  localparam logic [RXS_LNK_THR_W-1:0]   RXS_LNK_THR_MIN    = 3'h1;

endpackage

// ### rtl/rxs_flag_if.sv
// rxs_flag_if: events in and flags out between the status bank and one port's flag keeper.
// assumes: both ends on core_clk_in.
`timescale 1ns/1ns
`default_nettype none
interface rxs_flag_if import rxs_pkg::*; ();
  logic                    ev_lock;
  logic                    ev_seq;
  logic                    ev_par;
  logic [RXS_STK_W-1:0]    ev_stk;
  logic [RXS_DETAIL_W-1:0] ev_detail;
  logic                    enh;
  logic                    clr_sts1;
  logic                    clr_sts2;
  logic                    clr_detail;
  logic                    clr_parity;
  logic [RXS_PAR_W-1:0]    par_thresh;
  logic                    lock_chg;
  logic                    seq_flag;
  logic [RXS_STK_W-1:0]    stk;
  logic [RXS_DETAIL_W-1:0] detail;
  logic [RXS_PAR_W-1:0]    par_cnt;
  logic                    par_flag;

  modport bank  (output ev_lock, ev_seq, ev_par, ev_stk, ev_detail, enh, clr_sts1, clr_sts2,
                 clr_detail, clr_parity, par_thresh,
                 input lock_chg, seq_flag, stk, detail, par_cnt, par_flag);
  modport flags (input ev_lock, ev_seq, ev_par, ev_stk, ev_detail, enh, clr_sts1, clr_sts2,
                 clr_detail, clr_parity, par_thresh,
                 output lock_chg, seq_flag, stk, detail, par_cnt, par_flag);
endinterface
`default_nettype wire

// ### rtl/rxs_port_flags.sv
// rxs_port_flags: sticky flags and parity counter of one receive port.
// assumes: events are same-clock signals; clears are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
module rxs_port_flags import rxs_pkg::*; (
  input wire logic core_clk_in, // core clock
  input wire logic rst_n_in,    // async reset, active low
  rxs_flag_if.flags fif         // events in, flags out
);
  logic lock_prev_q;
  logic lock_rise;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) lock_prev_q <= 1'b0;
    else lock_prev_q <= fif.ev_lock;
  end
  assign lock_rise = fif.ev_lock & ~lock_prev_q;

  // set tested first so a change during the clearing read survives
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) fif.lock_chg <= 1'b0;
    else if (fif.ev_lock != lock_prev_q) fif.lock_chg <= 1'b1; // [RULE_01] [RULE_19]
    else if (fif.clr_sts1) fif.lock_chg <= 1'b0;               // [RULE_01]
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) fif.seq_flag <= 1'b0;
    else if (!fif.enh && fif.ev_seq) fif.seq_flag <= 1'b1;       // [RULE_02] [RULE_19]
    else if (!fif.enh && fif.clr_sts1) fif.seq_flag <= 1'b0;     // [RULE_02]
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) fif.detail <= '0;
    else fif.detail <= (fif.clr_detail ? '0 : fif.detail) | fif.ev_detail; // [RULE_03] [RULE_19]
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) fif.stk <= '0;
    else fif.stk <= (fif.clr_sts2 ? '0 : fif.stk) | fif.ev_stk; // [RULE_07] [RULE_08] [RULE_10] [RULE_13]
  end

  // counts from zero again after each fresh lock; saturates instead of wrapping
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) fif.par_cnt <= '0;
    else if (fif.clr_parity || lock_rise) fif.par_cnt <= {{(RXS_PAR_W-1){1'b0}}, fif.ev_par}; // [RULE_18]
    else if (fif.ev_par && fif.par_cnt != {RXS_PAR_W{1'b1}}) fif.par_cnt <= fif.par_cnt + 1'b1;
  end
  assign fif.par_flag = (fif.par_cnt > fif.par_thresh); // [RULE_04]

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_lock_chg_set: assert property ((fif.ev_lock != lock_prev_q) |=> fif.lock_chg) // [RULE_01]
    else $error("lock change not flagged");
  a_set_beats_clr: assert property (fif.ev_stk[RXS_STK_OVF] && fif.clr_sts2 |=> fif.stk[RXS_STK_OVF]) // [RULE_19]
    else $error("overflow event lost to clearing read");
  a_par_cleared: assert property (fif.clr_parity && !fif.ev_par |=> fif.par_cnt == '0 && !fif.par_flag) // [RULE_18]
    else $error("parity count not cleared");
  a_detail_clear: assert property (fif.clr_detail && fif.ev_detail == '0 |=> fif.detail == '0) // [RULE_03]
    else $error("detail not cleared by its read");
  a_seq_enh_hold: assert property (fif.enh && !fif.ev_seq |=> $stable(fif.seq_flag)) // [RULE_02]
    else $error("sequence flag moved in enhanced mode");
endmodule
`default_nettype wire

// ### testbench/rxs_remote_model.sv
// rxs_remote_model: remote serializer sending alarm words.
// assumes: shares the core clock; send_in is set off the rising edge.
`timescale 1ns/1ns
`default_nettype none
module rxs_remote_model (
  input  wire logic       clk_in,    // core clock
  input  wire logic [3:0] send_in,   // ports to load
  input  wire logic [5:0] word_in,   // csi,bcc,link,temp,v1,v0
  output logic      [3:0] valid_out, // load pulse
  output logic [3:0][5:0] alarm_out  // alarm flags
);
  initial valid_out = '0;
  initial alarm_out = '0;
  // flags keep moving between loads, so a stray load shows up
  always @(posedge clk_in) begin
    valid_out <= send_in;
    for (int i = 0; i < 4; i++)
      alarm_out[i] <= send_in[i] ? word_in : ~alarm_out[i];
  end
endmodule
`default_nettype wire

// ### testbench/rxs_status_bank_tb.sv
// rxs_status_bank_tb: register tests of the paged status bank.
// assumes: rxs_remote_model feeds the alarm inputs; one clock.
`timescale 1ns/1ns
`default_nettype none
module rxs_status_bank_tb;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, enh;
  logic [7:0] adr = 0, wd = 0, rdat;
  logic [3:0] lk = 0, ps = 0, par = 0, sq = 0, uw = 0, wc = 0, enc = 0, ovf = 0, lc = 0;
  logic [3:0] csi = 0, fs = 0, nc = 0, send = 0, av;
  logic [3:0][7:0] det = '0, fi = '0, ff = '0;
  logic [3:0][5:0] al;
  logic [5:0] aw = 0;
  int fail_count = 0, total_checks = 0;
  initial forever #25 clk = ~clk;
  rxs_status_bank dut (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(adr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdat), .rx_locked_in(lk), .rx_pass_in(ps),
    .parity_err_in(par), .ctrl_chan_sequence_fault_in(sq), .ctrl_chan_fault_detail_in(det),
    .line_width_unsteady_in(uw), .line_width_changed_in(wc), .link_encoding_fault_in(enc),
    .buffer_overflow_in(ovf), .line_total_changed_in(lc), .csi_receive_error_in(csi),
    .freq_measure_settled_in(fs), .link_clock_missing_in(nc), .freq_integer_mhz_in(fi),
    .freq_fraction_in(ff), .remote_alarm_valid_in(av), .remote_alarm_in(al),
    .enhanced_ctrl_fault_enable_out(enh));
  rxs_remote_model remote (.clk_in(clk), .send_in(send), .word_in(aw), .valid_out(av), .alarm_out(al));
  // ****
  // access tasks
  // ****
  task automatic chk(input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic w(input logic [7:0] a, d);
    @(negedge clk);
    adr = a;
    wd = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  // data sampled one and a half cycles after the read edge, well settled
  task automatic rc(input logic [7:0] a, e);
    @(negedge clk);
    adr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    @(negedge clk);
    chk(rdat, e);
  endtask
  task automatic pulse(ref logic [3:0] s);
    @(negedge clk);
    s = 4'h2;
    @(negedge clk);
    s = 4'h0;
  endtask
  task automatic final_report;
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    final_report;
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    rc(8'h4D, 8'h00);
    w(8'h4C, 8'h12);
    rc(8'h4C, 8'h12);
    lk = 4'h2;
    rc(8'h4D, 8'h51);
    ps = 4'h2;
    rc(8'h4D, 8'h43);
    pulse(sq);
    rc(8'h4D, 8'h4B);
    rc(8'h4D, 8'h43);
    w(8'h5D, 8'h02);
    repeat (2) pulse(par);
    rc(8'h4D, 8'h43);
    pulse(par);
    rc(8'h4D, 8'h47);
    rc(8'h55, 8'h00);
    rc(8'h56, 8'h03);
    rc(8'h4D, 8'h43);
    w(8'h5E, 8'h0A);
    {csi, fs, nc} = {3{4'h2}};
    @(negedge clk);
    {uw, wc, enc, ovf, lc} = {5{4'h3}};
    @(negedge clk);
    {uw, wc, enc, ovf, lc} = '0;
    rc(8'h4E, 8'hFF);
    rc(8'h4E, 8'h0E);
    w(8'h4C, 8'h02);
    rc(8'h4E, 8'hD1);
    w(8'h4C, 8'h12);
    fi[1] = 8'h5A;
    ff[1] = 8'h80;
    rc(8'h4F, 8'h5A);
    rc(8'h50, 8'h80);
    aw = 6'h2D;
    send = 4'h2;
    @(negedge clk);
    send = 4'h0;
    w(8'h51, 8'hFF);
    rc(8'h51, 8'h2D);
    w(8'h5A, 8'h01);
    chk({7'h0, enh}, 8'h01);
    det[1] = 8'h01;
    @(negedge clk);
    det[1] = 8'h00;
    rc(8'h4D, 8'h4B);
    rc(8'h4D, 8'h4B);
    rc(8'h5B, 8'h01);
    rc(8'h4D, 8'h43);
    final_report;
  end
endmodule
`default_nettype wire
